// File: rtl/itrc_pkg.sv
// Purpose: shared constants for the input terminal run control block
// Assumes: 10 MHz clock, times held in 0.1 s and 1 ms units
// Notes:   function codes and scheme codes are the programmed values
package itrc_pkg;
  localparam int          ITRC_NUM_TERM      = 5;
  localparam int          ITRC_CLK_HZ        = 10_000_000;
  localparam int          ITRC_MS_TICK_NS    = 1_000_000;  // 1 ms tick period in ns
  localparam int          ITRC_CLK_NS        = 100;
  localparam int          ITRC_MS_CYCLES     = ITRC_MS_TICK_NS / ITRC_CLK_NS;
  localparam int          ITRC_MS_PER_TENTH  = 100;         // 0.1 s in ms
  localparam logic [13:0] ITRC_MS_CNT_MAX    = 14'(ITRC_MS_CYCLES - 1);
  localparam logic [6:0]  ITRC_TENTH_CNT_MAX = 7'(ITRC_MS_PER_TENTH - 1);
  // timing limits and reset values
  localparam logic [6:0]  ITRC_FILT_MIN_MS   = 7'h02;
  localparam logic [6:0]  ITRC_FILT_MAX_MS   = 7'h64;
  localparam logic [6:0]  ITRC_FILT_DEF_MS   = 7'h0A;
  localparam logic [13:0] ITRC_DELAY_MAX     = 14'h270F;   // 999.9 s in 0.1 s
  localparam logic [13:0] ITRC_DELAY_DEF     = 14'h0000;
  localparam logic [15:0] ITRC_STEP_DEF      = 16'h0001;   // 0.1 Hz in 0.1 Hz units
  localparam logic [15:0] ITRC_FREQ_RST      = 16'h0000;
  localparam logic [2:0]  ITRC_SCHEME_DEF    = 3'h4;
  // terminal function codes
  localparam logic [4:0]  ITRC_FN_UP         = 5'h09;
  localparam logic [4:0]  ITRC_FN_DOWN       = 5'h0A;
  localparam logic [4:0]  ITRC_FN_DCBRAKE    = 5'h15;
  localparam logic [4:0]  ITRC_FN_ESTOP      = 5'h16;
  localparam logic [4:0]  ITRC_FN_HAND_LVL   = 5'h17;
  localparam logic [4:0]  ITRC_FN_HAND_EDGE  = 5'h18;
  // command source values that hand control to the terminals
  localparam logic [1:0]  ITRC_SRC_TERM_A    = 2'h1;
  localparam logic [1:0]  ITRC_SRC_TERM_B    = 2'h2;
  // scheme base modes (low two bits), bit 2 is auto-run
  localparam logic [1:0]  ITRC_MODE_2W1      = 2'h0;
  localparam logic [1:0]  ITRC_MODE_2W2      = 2'h1;
  localparam logic [1:0]  ITRC_MODE_3W1      = 2'h2;
  localparam logic [1:0]  ITRC_MODE_3W2      = 2'h3;
  localparam int          ITRC_AUTORUN_BIT   = 2;
endpackage : itrc_pkg

// File: rtl/itrc_term_cond.sv
// Purpose: one terminal: sync, debounce, on and off delays
// Assumes: ms_tick_in and tenth_tick_in are one-cycle enables
// Notes:   delays run on the debounced level
`timescale 1ns/1ps
module itrc_term_cond (
  input  wire logic        clock_in,        // 10 MHz clock
  input  wire logic        rst_in,          // async reset, high
  input  wire logic        pin_in,          // raw terminal level
  input  wire logic        ms_tick_in,      // 1 ms enable
  input  wire logic        tenth_tick_in,   // 0.1 s enable
  input  wire logic [6:0]  filt_ms_in,      // clamped filter time
  input  wire logic [13:0] on_delay_in,     // on delay, 0.1 s
  input  wire logic [13:0] off_delay_in,    // off delay, 0.1 s
  input  wire logic        interrupt_en_in, // delay may be cancelled
  output logic             level_out        // accepted level
);
  import itrc_pkg::*;

  logic        sync1_ff, sync2_ff;
  logic        stable_ff, nxt_stable;
  logic [6:0]  filt_cnt_ff, nxt_filt_cnt;
  logic        pend_ff, nxt_pend;
  logic [13:0] dly_cnt_ff, nxt_dly_cnt;
  logic        level_ff, nxt_level;

  // debounce: level held for the whole filter time before acceptance
  wire differs   = sync2_ff != stable_ff;
  wire filt_done = ms_tick_in && (filt_cnt_ff + 7'h01 >= filt_ms_in);
  assign nxt_filt_cnt = !differs ? 7'h00 : (ms_tick_in ? filt_cnt_ff + 7'h01 : filt_cnt_ff);
  assign nxt_stable   = (differs && filt_done) ? sync2_ff : stable_ff;

  // delay stage: applied to the debounced level
  wire [13:0] want_dly  = stable_ff ? on_delay_in : off_delay_in;
  wire        start     = !pend_ff && (stable_ff != level_ff);
  wire        cancel    = pend_ff && interrupt_en_in && (stable_ff == level_ff);
  wire        dly_done  = pend_ff && (dly_cnt_ff == 14'h0000);
  // without interruption a pending change completes even if the input fell back
  assign nxt_pend    = start ? (want_dly != 14'h0000) : (pend_ff && !cancel && !dly_done);
  assign nxt_dly_cnt = start ? want_dly :
                       (pend_ff && tenth_tick_in && dly_cnt_ff != 14'h0000) ? dly_cnt_ff - 14'h0001 : dly_cnt_ff;
  assign nxt_level   = (start && want_dly == 14'h0000) ? stable_ff :
                       (dly_done && !cancel) ? !level_ff : level_ff;
  assign level_out   = level_ff;

  // synchroniser, the first stage feeds only the second
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
    end else begin
      sync1_ff <= pin_in;
      sync2_ff <= sync1_ff;
    end
  end

  // filter and delay state
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      stable_ff   <= 1'b0;
      filt_cnt_ff <= 7'h00;
      pend_ff     <= 1'b0;
      dly_cnt_ff  <= ITRC_DELAY_DEF;
      level_ff    <= 1'b0;
    end else begin
      stable_ff   <= nxt_stable;
      filt_cnt_ff <= nxt_filt_cnt;
      pend_ff     <= nxt_pend;
      dly_cnt_ff  <= nxt_dly_cnt;
      level_ff    <= nxt_level;
    end
  end
endmodule : itrc_term_cond

// File: rtl/itrc_top.sv
// Purpose: terminal conditioning and run, stop, direction decode
// Assumes: settings are static ports from the drive controller
// Notes:   terminal one and two carry the run scheme, three is reverse in modes 2 and 3
//          function codes are read per terminal, so one pin can be a run
//          wire and carry an input function at the same time
//          the power-on window spans the filter time plus one ms tick past reset, so a level
//          held through reset counts as present at power-on
//          on and off delays are not waited for by that window
//          the divider free-runs from reset: filter times carry 0 to 1 ms
//          of jitter and delays 0 to 0.1 s
`timescale 1ns/1ps
module itrc_top (
  input  wire logic        clock_in,                  // 10 MHz clock
  input  wire logic        rst_in,                    // async reset, high
  input  wire logic        input_terminal_one_in,     // terminal pin 1
  input  wire logic        input_terminal_two_in,     // terminal pin 2
  input  wire logic        input_terminal_three_in,   // terminal pin 3
  input  wire logic        input_terminal_four_in,    // terminal pin 4
  input  wire logic        input_terminal_five_in,    // terminal pin 5
  input  wire logic [24:0] term_function_in,          // 5 bits per terminal
  input  wire logic [69:0] on_delay_in,               // 14 bits per terminal
  input  wire logic [69:0] off_delay_in,              // 14 bits per terminal
  input  wire logic        delay_interrupt_enable_in, // 1 lets delays be cancelled
  input  wire logic [1:0]  command_source_select_in,  // 1 or 2 = terminals
  input  wire logic [2:0]  terminal_scheme_select_in, // scheme 0..7
  input  wire logic [6:0]  input_filter_time_in,      // debounce, ms
  input  wire logic [15:0] frequency_step_size_in,    // 0.1 Hz units
  input  wire logic [15:0] upper_frequency_limit_in,  // 0.1 Hz units
  input  wire logic [1:0]  stop_mode_select_in,       // normal stop mode
  output logic             run_out,                   // motor run command
  output logic             reverse_out,               // 1 = reverse
  output logic             dc_brake_stop_out,         // brake-assisted stop
  output logic [1:0]       stop_mode_out,             // stop mode to apply
  output logic             emergency_stop_out,        // emergency stop
  output logic             hand_mode_out,             // hand operation
  output logic [15:0]      set_frequency_out,         // set frequency
  output logic [4:0]       term_level_out             // accepted levels
);
  import itrc_pkg::*;

  // function code of terminal i; five bits per terminal, terminal one
  // in the lowest bits
  function automatic logic [4:0] fn_of(input logic [24:0] fv, input int i);
    fn_of = fv[i*5 +: 5];
  endfunction : fn_of

  // true when any active terminal carries the given function
  // several terminals may carry one function; any of them acts, so a
  // second emergency stop contact needs no extra logic
  function automatic logic fn_active(input logic [24:0] fv, input logic [4:0] lv, input logic [4:0] code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < ITRC_NUM_TERM; i++) begin
      if (lv[i] && fn_of(fv, i) == code) begin
        hit = 1'b1;
      end
    end
    fn_active = hit;
  endfunction : fn_active

  // divider, edge history, run decode and output state
  // the nxt_ values are the combinational next state of the register that each one is named for
  logic [13:0] ms_cnt_ff, nxt_ms_cnt;
  logic [6:0]  tenth_cnt_ff, nxt_tenth_cnt;
  logic        ms_tick_ff, tenth_tick_ff;
  logic [4:0]  lvl;
  logic [4:0]  lvl_d_ff;
  logic        run_ff, nxt_run;
  logic        rev_ff, nxt_rev;
  logic        hand_edge_ff, nxt_hand_edge;
  logic        power_on_ff;
  logic [6:0]  pwr_ms_ff;     // ms ticks seen in the power-on window
  logic [15:0] freq_ff, nxt_freq;
  logic        estop_ff, dcb_ff, hand_ff;
  logic [1:0]  stop_mode_ff;

  // raw pins in terminal order; each conditioner synchronises its own pin,
  // so nothing in this module reads them before the two flip-flops
  wire [4:0] pins = {input_terminal_five_in, input_terminal_four_in, input_terminal_three_in,
                     input_terminal_two_in, input_terminal_one_in};

  // filter time held inside its legal span
  // a bad setting is pulled to the nearest legal value rather than refused,
  // so the filter can never be switched off by mistake
  wire [6:0] filt_ms = (input_filter_time_in < ITRC_FILT_MIN_MS) ? ITRC_FILT_MIN_MS :
                       (input_filter_time_in > ITRC_FILT_MAX_MS) ? ITRC_FILT_MAX_MS :
                       input_filter_time_in;

  // time base: 1 ms then 0.1 s enables from one divider chain
  // both enables are registered, so all conditioners see a tick in the same
  // cycle and terminals pressed together are accepted together
  // the divider is never restarted after reset
  assign nxt_ms_cnt    = (ms_cnt_ff == ITRC_MS_CNT_MAX) ? 14'h0000 : ms_cnt_ff + 14'h0001;
  wire   ms_wrap       = ms_cnt_ff == ITRC_MS_CNT_MAX;
  wire   tenth_wrap    = ms_wrap && (tenth_cnt_ff == ITRC_TENTH_CNT_MAX);
  assign nxt_tenth_cnt = !ms_wrap ? tenth_cnt_ff : (tenth_wrap ? 7'h00 : tenth_cnt_ff + 7'h01);

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      ms_cnt_ff     <= 14'h0000;
      tenth_cnt_ff  <= 7'h00;
      ms_tick_ff    <= 1'b0;
      tenth_tick_ff <= 1'b0;
    end else begin
      ms_cnt_ff     <= nxt_ms_cnt;
      tenth_cnt_ff  <= nxt_tenth_cnt;
      ms_tick_ff    <= ms_wrap;
      tenth_tick_ff <= tenth_wrap;
    end
  end

  // one conditioner per terminal
  // delays are clamped to 999.9 s so an out-of-range setting cannot
  // stretch a terminal beyond its span; the filter time is shared
  for (genvar g = 0; g < ITRC_NUM_TERM; g++) begin : g_term
    itrc_term_cond u_cond (
      .clock_in        (clock_in),
      .rst_in          (rst_in),
      .pin_in          (pins[g]),
      .ms_tick_in      (ms_tick_ff),
      .tenth_tick_in   (tenth_tick_ff),
      .filt_ms_in      (filt_ms),
      .on_delay_in     ((on_delay_in[g*14 +: 14] > ITRC_DELAY_MAX) ? ITRC_DELAY_MAX : on_delay_in[g*14 +: 14]),
      .off_delay_in    ((off_delay_in[g*14 +: 14] > ITRC_DELAY_MAX) ? ITRC_DELAY_MAX : off_delay_in[g*14 +: 14]),
      .interrupt_en_in (delay_interrupt_enable_in),
      .level_out       (lvl[g])
    );
  end

  // input functions decoded from accepted levels
  // codes are read live, so changing a code while its terminal is closed
  // acts at once; edges come only from accepted levels, never from pins
  wire dcb_req      = fn_active(term_function_in, lvl, ITRC_FN_DCBRAKE);
  wire estop_req    = fn_active(term_function_in, lvl, ITRC_FN_ESTOP);
  wire hand_lvl     = fn_active(term_function_in, lvl, ITRC_FN_HAND_LVL);
  wire hand_e_now   = fn_active(term_function_in, lvl, ITRC_FN_HAND_EDGE);
  wire hand_e_prev  = fn_active(term_function_in, lvl_d_ff, ITRC_FN_HAND_EDGE);
  wire up_rise      = fn_active(term_function_in, lvl & ~lvl_d_ff, ITRC_FN_UP);
  wire down_rise    = fn_active(term_function_in, lvl & ~lvl_d_ff, ITRC_FN_DOWN);

  // edge-triggered hand toggles on each rising edge
  // the toggle keeps hand mode between presses; a held level cannot toggle
  // again because the edge is taken against the delayed level
  assign nxt_hand_edge = (hand_e_now && !hand_e_prev) ? !hand_edge_ff : hand_edge_ff;

  // frequency stepping, limited to zero and the upper limit
  // up and down edges in one cycle cancel; a step larger than the limit
  // is cut to it, and a step that would pass the limit parks on it
  wire [16:0] f_up   = {1'b0, freq_ff} + {1'b0, frequency_step_size_in};
  wire        step_ok = frequency_step_size_in <= upper_frequency_limit_in;
  wire [15:0] step   = step_ok ? frequency_step_size_in : upper_frequency_limit_in;
  assign nxt_freq = (up_rise && !down_rise) ?
                      ((f_up > {1'b0, upper_frequency_limit_in}) ? upper_frequency_limit_in : freq_ff + step) :
                    (down_rise && !up_rise) ?
                      ((freq_ff < step) ? 16'h0000 : freq_ff - step) : freq_ff;

  // scheme decode; terminals one, two and three carry the run wiring
  // bit 2 only chooses auto-run, so modes 4 to 7 share the decode of
  // modes 0 to 3; a source other than the terminals forces run low, but direction still follows the scheme
  wire       term_src  = (command_source_select_in == ITRC_SRC_TERM_A) ||
                         (command_source_select_in == ITRC_SRC_TERM_B);
  wire [1:0] base_mode = terminal_scheme_select_in[1:0];
  wire       auto_run  = terminal_scheme_select_in[ITRC_AUTORUN_BIT];
  wire       t1 = lvl[0];
  wire       t2 = lvl[1];
  wire       t3 = lvl[2];
  // inside the power-on window no accepted edge may start the motor; only
  // the auto-run path can, so stop-at-power-on modes stay stopped there
  wire       t1_rise = lvl[0] && !lvl_d_ff[0] && !power_on_ff;
  wire       lvl_moved = (lvl != lvl_d_ff) && !power_on_ff;
  wire       t3_rise = lvl[2] && !lvl_d_ff[2];
  // level schemes also use the start condition held at power-on
  // in the three-wire modes it is run and halt together, so an open
  // halt contact blocks auto-run
  wire       start_cond = (base_mode == ITRC_MODE_2W1) ? (t1 ^ t2) :
                          (base_mode == ITRC_MODE_2W2) ? t1 : t1 && t2;
  wire       pwr_start  = power_on_ff && auto_run && start_cond;
  wire       hard_stop  = estop_req || dcb_req;

  // run and direction decode
  // mode 0: one terminal each for forward and reverse; both or none stops
  // mode 1: terminal one enables, terminal two picks reverse
  // mode 2: terminal one is the run button, terminal two the normally
  //         closed halt button, terminal three a direction switch
  // mode 3: as mode 2, but terminal three is a button that flips direction
  // a missing terminal source or a stop input then forces run low; stop
  // inputs are levels, so run cannot creep back while they stand
  always_comb begin
    nxt_run = run_ff;
    nxt_rev = rev_ff;
    case (base_mode)
      ITRC_MODE_2W1: begin
        // level scheme; after power-on only a fresh edge restarts unless auto-run
        nxt_run = (t1 ^ t2) && (run_ff || pwr_start || lvl_moved);
        nxt_rev = t2 && !t1 ? 1'b1 : (t1 && !t2 ? 1'b0 : rev_ff);
      end
      ITRC_MODE_2W2: begin
        nxt_run = t1 && (run_ff || pwr_start || t1_rise);
        nxt_rev = t2;
      end
      ITRC_MODE_3W1: begin
        // halt_button is normally closed: low level stops
        nxt_run = t2 && (run_ff || t1_rise || pwr_start);
        nxt_rev = t3;
      end
      ITRC_MODE_3W2: begin
        nxt_run = t2 && (run_ff || t1_rise || pwr_start);
        nxt_rev = t3_rise ? !rev_ff : rev_ff;
      end
      default: begin
        nxt_run = 1'b0;
        nxt_rev = rev_ff;
      end
    endcase
    if (!term_src || hard_stop) begin
      nxt_run = 1'b0;
    end
  end

  // run state and edge history; lvl_d_ff resets to the idle level of the
  // pins, so no false edge follows reset
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      lvl_d_ff     <= 5'h00;
      run_ff       <= 1'b0;
      rev_ff       <= 1'b0;
      hand_edge_ff <= 1'b0;
      freq_ff      <= ITRC_FREQ_RST;
    end else begin
      lvl_d_ff     <= lvl;
      run_ff       <= nxt_run;
      rev_ff       <= nxt_rev;
      hand_edge_ff <= nxt_hand_edge;
      freq_ff      <= nxt_freq;
    end
  end

  // power-on window: open from reset until one ms tick past the filter time
  // a terminal held through reset is accepted on the filter-th tick, so the
  // window still stands when its level first shows and auto-run can act
  // the count stops with the window, so it cannot wrap on a long run
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      pwr_ms_ff   <= 7'h00;
      power_on_ff <= 1'b1;
    end else if (ms_tick_ff && power_on_ff) begin
      pwr_ms_ff   <= pwr_ms_ff + 7'h01;
      power_on_ff <= pwr_ms_ff < filt_ms;
    end
  end

  // registered stop outputs
  // estop masks the brake flag so the two stop outputs never stand together;
  // the selected stop mode is passed on unchanged; the brake flag does not alter it
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      estop_ff     <= 1'b0;
      dcb_ff       <= 1'b0;
      hand_ff      <= 1'b0;
      stop_mode_ff <= 2'h0;
    end else begin
      estop_ff     <= estop_req;
      dcb_ff       <= dcb_req && !estop_req;
      hand_ff      <= hand_lvl || hand_edge_ff;
      stop_mode_ff <= stop_mode_select_in;       // passed on whatever the brake flag
    end
  end

  // every output comes straight from a flip-flop; term_level_out shows
  // the levels the conditioners accepted, after filter and delays
  // so the run decode and the outside world see the same levels
  assign run_out            = run_ff;
  assign reverse_out        = rev_ff;
  assign emergency_stop_out = estop_ff;
  assign dc_brake_stop_out  = dcb_ff;
  assign stop_mode_out      = stop_mode_ff;
  assign hand_mode_out      = hand_ff;
  assign set_frequency_out  = freq_ff;
  assign term_level_out     = lvl;
endmodule : itrc_top

// File: sim/itrc_props.sv
// Purpose: port-level assertions for itrc_top
// Assumes: one clock domain, async high reset
// Notes:   terminal functions decoded here from term_function_in
`timescale 1ns/1ps
module itrc_props
  import itrc_pkg::*;
(
  input wire logic        clock_in,                  // clock
  input wire logic        rst_in,                    // reset
  input wire logic [24:0] term_function_in,          // functions
  input wire logic [1:0]  command_source_select_in,  // source
  input wire logic [2:0]  terminal_scheme_select_in, // scheme
  input wire logic [15:0] frequency_step_size_in,    // step
  input wire logic        run_out,                   // run
  input wire logic        reverse_out,               // direction
  input wire logic        dc_brake_stop_out,         // brake stop
  input wire logic        emergency_stop_out,        // estop
  input wire logic        hand_mode_out,             // hand
  input wire logic [15:0] set_frequency_out,         // frequency
  input wire logic [4:0]  term_level_out             // levels
);
  // true when any accepted terminal carries the given function
  function automatic logic fn_on(input logic [4:0] code, input logic [24:0] f, input logic [4:0] l);
    fn_on = 1'b0;
    for (int i = 0; i < 5; i++) if (l[i] && f[5*i+:5] == code) fn_on = 1'b1;
  endfunction : fn_on
  wire estop_req = fn_on(ITRC_FN_ESTOP, term_function_in, term_level_out);
  wire dc_req    = fn_on(ITRC_FN_DCBRAKE, term_function_in, term_level_out);
  wire hand_req  = fn_on(ITRC_FN_HAND_LVL, term_function_in, term_level_out);
  wire up_lvl    = fn_on(ITRC_FN_UP, term_function_in, term_level_out);
  wire dn_lvl    = fn_on(ITRC_FN_DOWN, term_function_in, term_level_out);
  wire src_ok    = command_source_select_in inside {ITRC_SRC_TERM_A, ITRC_SRC_TERM_B};
  logic [4:0]  lvl_d_ff;
  logic        up_d_ff;
  logic [2:0]  age_ff;
  logic [15:0] base_ff;
  // age since last level change; frequency may only move just after one
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      lvl_d_ff <= 5'h00;
      up_d_ff  <= 1'b0;
      age_ff   <= 3'h0;
      base_ff  <= 16'h0000;
    end else begin
      lvl_d_ff <= term_level_out;
      up_d_ff  <= up_lvl;
      age_ff   <= (term_level_out != lvl_d_ff) ? 3'h0 : ((age_ff == 3'h7) ? age_ff : age_ff + 3'h1);
      if (up_lvl && !up_d_ff) base_ff <= set_frequency_out;
    end
  end
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  a_estop_no_run: assert property (emergency_stop_out [*2] |-> !run_out)
    else $error("run high during emergency stop");
  a_brake_no_run: assert property (dc_brake_stop_out [*2] |-> !run_out)
    else $error("run high during brake stop");
  a_source_gates_run: assert property (!src_ok [*3] |-> !run_out)
    else $error("run high with source not terminals");
  a_estop_follows: assert property (estop_req |-> ##[0:2] emergency_stop_out)
    else $error("estop input not acted on");
  a_brake_follows: assert property (dc_req && !estop_req |-> ##[0:2] dc_brake_stop_out)
    else $error("brake input not acted on");
  a_hand_follows: assert property (hand_req |-> ##[0:2] hand_mode_out)
    else $error("hand level input not acted on");
  a_freq_needs_edge: assert property ($changed(set_frequency_out) |-> age_ff < 3'h4)
    else $error("frequency moved without a terminal edge");
  a_step_size_up: assert property (up_lvl && !up_d_ff && !dn_lvl && set_frequency_out == 16'h0000
    |-> ##[1:2] set_frequency_out == base_ff + frequency_step_size_in)
    else $error("up step wrong size");
  a_mode0_forward: assert property ((terminal_scheme_select_in[1:0] == ITRC_MODE_2W1 && run_out
    && term_level_out[0] && !term_level_out[1]) [*2] |-> !reverse_out)
    else $error("mode 0 forward ran reversed");
  c_run: cover property ($rose(run_out));
  c_estop: cover property ($rose(emergency_stop_out));
  c_freq: cover property ($changed(set_frequency_out));
endmodule : itrc_props

// File: sim/itrc_switch_model.sv
// Purpose: contacts and push buttons wired to the five terminals
// Assumes: press_in is the settled contact state wanted by the bench
// Notes:   every change chatters for 40 cycles, far inside the filter
`timescale 1ns/1ps
module itrc_switch_model (
  input  wire logic       clock_in, // bench clock
  input  wire logic [4:0] press_in, // wanted contact state
  output logic      [4:0] pin_out   // level seen at terminals
);
  logic [4:0] last_ff;
  logic [4:0] chg_ff;
  int         bounce_cnt;
  initial begin
    pin_out = 5'h00;
    last_ff = 5'h00;
    chg_ff = 5'h00;
    bounce_cnt = 0;
  end
  // real contacts bounce; only the bits that moved chatter
  always @(posedge clock_in) begin
    if (press_in != last_ff) begin
      chg_ff = press_in ^ last_ff;
      bounce_cnt = 40;
    end
    last_ff = press_in;
    if (bounce_cnt > 0) bounce_cnt--;
    pin_out <= press_in ^ (chg_ff & {5{bounce_cnt[2]}});
  end
endmodule : itrc_switch_model

// File: sim/itrc_top_tb_top.sv
// Purpose: self-checking bench for itrc_top
// Assumes: 2 ms filter, zero delays; each acceptance waits 2.1 ms
// Notes:   terminal four swaps function to reach brake and hand paths
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin bad_count++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module itrc_top_tb_top;
  import itrc_pkg::*;
  typedef struct {logic [4:0] prs; logic [1:0] src; logic ie; logic [15:0] stp;
    logic [4:0] lvl; logic run; logic est; logic [15:0] frq;} itrc_row_s;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic [4:0] press = 5'h00, pins;
  logic [24:0] fn = {ITRC_FN_UP, ITRC_FN_ESTOP, 15'h0000};
  logic [1:0] src = 2'h1, stop_sel = 2'h0, stop_mode;
  logic ie = 1'b1, run, rev, dcb, est, hand;
  logic [2:0] scheme = 3'h4;
  logic [15:0] step = 16'h0005, freq;
  logic [4:0] lvl;
  int bad_count = 0, checks = 0;
  itrc_row_s rows [2] = '{'{5'h11, 2'h1, 1'b1, 16'h0005, 5'h11, 1'b1, 1'b0, 16'h0005},
                          '{5'h19, 2'h2, 1'b0, 16'h0003, 5'h19, 1'b0, 1'b1, 16'h0005}};
  always #50 clock_in = ~clock_in;
  itrc_switch_model u_sw (.clock_in(clock_in), .press_in(press), .pin_out(pins));
  itrc_top uut (.clock_in(clock_in), .rst_in(rst_in), .input_terminal_one_in(pins[0]),
    .input_terminal_two_in(pins[1]), .input_terminal_three_in(pins[2]), .input_terminal_four_in(pins[3]),
    .input_terminal_five_in(pins[4]), .term_function_in(fn), .on_delay_in(70'h0), .off_delay_in(70'h0),
    .delay_interrupt_enable_in(ie), .command_source_select_in(src), .terminal_scheme_select_in(scheme),
    .input_filter_time_in(7'h02), .frequency_step_size_in(step), .upper_frequency_limit_in(16'h0064),
    .stop_mode_select_in(stop_sel), .run_out(run), .reverse_out(rev), .dc_brake_stop_out(dcb),
    .stop_mode_out(stop_mode), .emergency_stop_out(est), .hand_mode_out(hand),
    .set_frequency_out(freq), .term_level_out(lvl));
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask : cyc
  task automatic complete_run();
    if (bad_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  // watchdog sized for about 84k cycles of planned traffic
  initial begin
    #9_500_000;
    bad_count++;
    complete_run();
  end
  initial begin
    cyc(16);
    rst_in = 1'b0;
    // row 0 is pressed inside the power-on window and starts by auto-run
    foreach (rows[i]) begin
      press = rows[i].prs;
      src = rows[i].src;
      ie = rows[i].ie;
      step = rows[i].stp;
      cyc(21000);
      `CHK(lvl, rows[i].lvl)
      `CHK(run, rows[i].run)
      `CHK(rev, 1'b0)
      `CHK(est, rows[i].est)
      `CHK(freq, rows[i].frq)
    end
    // stop behaviour swapped in place while terminal four stays closed
    fn[19:15] = ITRC_FN_DCBRAKE;
    stop_sel = 2'h2;
    cyc(4);
    `CHK(dcb, 1'b1)
    `CHK(run, 1'b0)
    `CHK(stop_mode, 2'h2)
    fn[19:15] = ITRC_FN_HAND_LVL;
    cyc(4);
    `CHK(hand, 1'b1)
    `CHK(dcb, 1'b0)
    // five lowers, three toggles hand; all open while two pulses for 1 ms
    fn = {ITRC_FN_DOWN, 5'h00, ITRC_FN_HAND_EDGE, 10'h000};
    press = 5'h02;
    cyc(10000);
    press = 5'h00;
    cyc(11000);
    `CHK(lvl, 5'h00)
    `CHK(rev, 1'b0)
    `CHK(hand, 1'b0)
    `CHK(freq, 16'h0005)
    // mode 3: run, halt and reverse close together; five steps down by 3
    scheme = 3'h3;
    press = 5'h17;
    cyc(21000);
    `CHK(lvl, 5'h17)
    `CHK(run, 1'b1)
    `CHK(rev, 1'b1)
    `CHK(hand, 1'b1)
    `CHK(freq, 16'h0002)
    rst_in = 1'b1;
    cyc(2);
    `CHK({run, rev, dcb, est, hand, stop_mode, freq, lvl}, 28'h0000000)
    rst_in = 1'b0;
    cyc(3);
    `CHK({run, lvl}, 6'h00)
    complete_run();
  end
endmodule : itrc_top_tb_top
bind itrc_top itrc_props u_props (.clock_in(clock_in), .rst_in(rst_in), .term_function_in(term_function_in),
  .command_source_select_in(command_source_select_in), .terminal_scheme_select_in(terminal_scheme_select_in),
  .frequency_step_size_in(frequency_step_size_in), .run_out(run_out), .reverse_out(reverse_out),
  .dc_brake_stop_out(dc_brake_stop_out), .emergency_stop_out(emergency_stop_out), .hand_mode_out(hand_mode_out),
  .set_frequency_out(set_frequency_out), .term_level_out(term_level_out));
